// >>> rcs_pkg.sv
// constants and types for the reset-cause and start-up sequencer
package rcs_pkg;
   // =====================================================
   // register addresses
   localparam logic [1:0] ADDR_PWRCTL = 2'h0;
   localparam logic [1:0] ADDR_BORCTL = 2'h1;
   localparam logic [1:0] ADDR_STATUS = 2'h2;

   // =====================================================
   // power-control register fields
   localparam int BIT_STK_OVER  = 7;
   localparam int BIT_STK_UNDER = 6;
   localparam int BIT_UNUSED    = 5;
   localparam int BIT_WDT       = 4;
   localparam int BIT_PIN_RST   = 3;
   localparam int BIT_OPCODE    = 2;
   localparam int BIT_POR    = 1;
   localparam int BIT_BOR    = 0;
   localparam logic [7:0] PWRCTL_IMPL_MASK = 8'hDF;

   // status register fields
   localparam int BIT_TIMEOUT   = 4;
   localparam int BIT_POWERDOWN = 3;

   // brown-out control fields
   localparam int BIT_SOFT_BO  = 7;
   localparam int BIT_FAST_BO  = 6;
   localparam int BIT_READY_BO = 0;

   // =====================================================
   // reset values
   localparam logic [7:0]  PWRCTL_POR_VAL = 8'h1C;
   localparam logic [1:0]  BOCTL_RST      = 2'h2;
   localparam logic [2:0]  STATUS_LOW_RST = 3'h0;
   localparam logic [10:0] RESET_VECTOR   = 11'h000;
   localparam logic [10:0] IRQ_VECTOR     = 11'h004;

   // =====================================================
   // timing
   localparam int CLK_MHZ         = 20;
   localparam int PIN_DELAY_OSC   = 10;
   localparam int PIN_DELAY_CYC   = PIN_DELAY_OSC;
   localparam int PWRT_DEFAULT    = 1310720;

   // =====================================================
   // sequencer states, gray along the usual path
   typedef enum logic [2:0] {
      ST_HOLD  = 3'b000,
      ST_PWRT  = 3'b001,
      ST_MCLRW = 3'b011,
      ST_DLY   = 3'b010,
      ST_RUN   = 3'b110,
      ST_SLEEP = 3'b111
   } rcs_state_t;
endpackage

// >>> rcs_reset_seq.sv
// reset-cause flags and start-up sequencer
`timescale 1ns/100ps

// Function
// RULE1 - programming exit acts as power-on reset
// RULE2 - power-up timer only when enable_n low
// RULE3 - run needs timer done and pin released
// RULE4 - timer ignores pin; 10 cycles after release
// RULE5 - every true reset loads counter zero
// RULE6 - wake continues next; interrupt vectors after
// RULE7 - power-on sets timeout and powerdown flags
// RULE8 - power-on clears stack, POR; sets three
// RULE9 - brown-out flag update pattern
// RULE10 - watchdog clears its flag and timeout
// RULE11 - master clear flag; sleep adjusts status
// RULE12 - reset opcode clears only its flag
// RULE13 - stack overflow sets flag when enabled
// RULE14 - stack underflow sets flag when enabled
// RULE15 - interrupt wake sets timeout, clears powerdown
// RULE16 - cause flags cleared by hardware only; a firmware write to the power-control register also loads them, zeros included
// RULE17 - power-control bit five reads zero
// RULE18 - timer starts after power reset release
// RULE19 - pin enabled by low-volt or enable bit
// RULE20 - timer length is a parameter
module rcs_reset_seq
   import rcs_pkg::*;
#(
   parameter int PWRT_CYCLES = PWRT_DEFAULT // [RULE20]
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        porEvent,
   input  wire logic        borEvent,
   input  wire logic        progExit,
   input  wire logic        powerupTimerEnableN,
   input  wire logic        masterClearEnable,
   input  wire logic        lowVoltProgEnable,
   input  wire logic        stackResetEnable,
   input  wire logic        masterClearPinN,
   input  wire logic        wdtTimeout,
   input  wire logic        resetOpcode,
   input  wire logic        stackOverflow,
   input  wire logic        stackUnderflow,
   input  wire logic        sleepEnter,
   input  wire logic        irqWake,
   input  wire logic        globalIrqEnable,
   input  wire logic        borReady,
   input  wire logic [10:0] curPc,
   input  wire logic [1:0]  regAddr,
   input  wire logic [7:0]  regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic [7:0]       regRdata,
   output logic             cpuRun,
   output logic             coreReset,
   output logic             pcLoad,
   output logic [10:0]      pcValue,
   output logic             irqPush,
   output logic             sleeping,
   output logic             softBorEnable,
   output logic             borFastStart
);

   // =====================================================
   // event decode
   logic powerRst;
   logic pinRstOn;
   logic pinRst;
   logic stkOvfRst;
   logic stkUnfRst;
   logic wdtRst;
   logic wdtWake;
   logic intWake;
   logic trueRst;
   logic pwrCtlWr;
   logic statusWr;
   logic borCtlWr;
   rcs_state_t state_r;
   logic [21:0] pwrtCnt_r;
   logic [3:0]  dlyCnt_r;
   logic        sleepNext_r;

   assign powerRst  = porEvent | progExit;                  // [RULE1]
   assign pinRstOn  = lowVoltProgEnable | masterClearEnable; // [RULE19]
   assign pinRst    = pinRstOn & ~masterClearPinN;
   assign stkOvfRst = stackResetEnable & stackOverflow;
   assign stkUnfRst = stackResetEnable & stackUnderflow;
   assign wdtRst    = wdtTimeout & (state_r != ST_SLEEP);
   assign wdtWake   = wdtTimeout & (state_r == ST_SLEEP);
   assign intWake   = irqWake & (state_r == ST_SLEEP);
   assign trueRst   = powerRst | borEvent | pinRst | wdtRst | resetOpcode
                      | stkOvfRst | stkUnfRst;
   assign pwrCtlWr  = regWr & (regAddr == ADDR_PWRCTL);
   assign statusWr  = regWr & (regAddr == ADDR_STATUS);
   assign borCtlWr  = regWr & (regAddr == ADDR_BORCTL);

   // =====================================================
   // start-up sequencer
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= ST_HOLD;
      end else if (powerRst | borEvent) begin
         state_r <= ST_HOLD;                                // [RULE18]
      end else begin
         case (state_r)
            ST_HOLD: begin
               if (!powerupTimerEnableN) begin
                  state_r <= ST_PWRT;                       // [RULE2]
               end else begin
                  state_r <= ST_MCLRW;
               end
            end
            ST_PWRT: begin
               // timer counts even while the pin is held low
               if (pwrtCnt_r >= 22'(PWRT_CYCLES - 1)) begin
                  state_r <= ST_MCLRW;                      // [RULE4]
               end
            end
            ST_MCLRW: begin
               if (!pinRst) begin
                  state_r <= ST_DLY;                        // [RULE3]
               end
            end
            ST_DLY: begin
               if (pinRst) begin
                  state_r <= ST_MCLRW;
               end else if (dlyCnt_r == 4'(PIN_DELAY_CYC - 1)) begin
                  state_r <= ST_RUN;                        // [RULE4]
               end
            end
            ST_RUN: begin
               if (pinRst | wdtRst | resetOpcode | stkOvfRst | stkUnfRst) begin
                  state_r <= ST_MCLRW;
               end else if (sleepEnter) begin
                  state_r <= ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               if (pinRst) begin
                  state_r <= ST_MCLRW;
               end else if (wdtWake | intWake) begin
                  state_r <= ST_RUN;                        // [RULE6]
               end
            end
            default: state_r <= ST_HOLD;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pwrtCnt_r <= 22'h000000;
      end else if (state_r == ST_PWRT) begin
         pwrtCnt_r <= pwrtCnt_r + 22'h000001;
      end else begin
         pwrtCnt_r <= 22'h000000;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dlyCnt_r <= 4'h0;
      end else if (state_r == ST_DLY) begin
         dlyCnt_r <= dlyCnt_r + 4'h1;
      end else begin
         dlyCnt_r <= 4'h0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cpuRun    <= 1'b0;
         coreReset <= 1'b1;
         sleeping  <= 1'b0;
      end else begin
         cpuRun    <= (state_r == ST_RUN) & ~trueRst;
         coreReset <= (state_r != ST_RUN) & (state_r != ST_SLEEP) | trueRst;
         sleeping  <= (state_r == ST_SLEEP) & ~(wdtWake | intWake | trueRst);
      end
   end

   // =====================================================
   // program counter load
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pcLoad      <= 1'b1;
         pcValue     <= RESET_VECTOR;
         irqPush     <= 1'b0;
         sleepNext_r <= 1'b0;
      end else begin
         pcLoad      <= 1'b0;
         irqPush     <= 1'b0;
         sleepNext_r <= 1'b0;
         if (trueRst) begin
            pcLoad  <= 1'b1;
            pcValue <= RESET_VECTOR;                        // [RULE5]
         end else if (wdtWake | intWake) begin
            pcLoad      <= 1'b1;
            pcValue     <= curPc + 11'h001;                 // [RULE6]
            sleepNext_r <= intWake & globalIrqEnable;
         end else if (sleepNext_r) begin
            // next instruction has run; now take the vector
            pcLoad  <= 1'b1;
            pcValue <= IRQ_VECTOR;                          // [RULE6]
            irqPush <= 1'b1;
         end
      end
   end

   // =====================================================
   // power-control flags (events win over firmware writes)
   logic [7:0] pwrCtl_r;
   logic [7:0] pwrCtl_nxt;

   always_comb begin
      pwrCtl_nxt = pwrCtl_r;
      if (pwrCtlWr) begin
         pwrCtl_nxt = regWdata & PWRCTL_IMPL_MASK;          // [RULE17]
      end
      if (powerRst) begin
         pwrCtl_nxt = PWRCTL_POR_VAL | {7'h00, pwrCtl_r[BIT_BOR]}; // [RULE8]
      end else begin
         if (borEvent) begin
            pwrCtl_nxt[BIT_STK_OVER]  = 1'b0;               // [RULE9]
            pwrCtl_nxt[BIT_STK_UNDER] = 1'b0;
            pwrCtl_nxt[BIT_PIN_RST]   = 1'b1;
            pwrCtl_nxt[BIT_OPCODE]    = 1'b1;
            pwrCtl_nxt[BIT_POR]    = pwrCtl_r[BIT_POR];
            pwrCtl_nxt[BIT_WDT]    = pwrCtl_r[BIT_WDT];
            pwrCtl_nxt[BIT_BOR]    = 1'b0;
         end
         if (wdtRst) begin
            pwrCtl_nxt[BIT_WDT] = 1'b0;                     // [RULE10] [RULE16]
         end
         if (pinRst) begin
            pwrCtl_nxt[BIT_PIN_RST] = 1'b0;                 // [RULE11] [RULE16]
         end
         if (resetOpcode) begin
            pwrCtl_nxt[BIT_OPCODE] = 1'b0;                  // [RULE12] [RULE16]
         end
         if (stkOvfRst) begin
            pwrCtl_nxt[BIT_STK_OVER] = 1'b1;                // [RULE13]
         end
         if (stkUnfRst) begin
            pwrCtl_nxt[BIT_STK_UNDER] = 1'b1;               // [RULE14]
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pwrCtl_r <= PWRCTL_POR_VAL;
      end else begin
         pwrCtl_r <= pwrCtl_nxt;
      end
   end

   // =====================================================
   // status timeout / powerdown and low status bits
   logic timeout_r;
   logic powerdown_r;
   logic [2:0] statusLow_r;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         timeout_r   <= 1'b1;
         powerdown_r <= 1'b1;
         statusLow_r <= STATUS_LOW_RST;
      end else begin
         if (statusWr) begin
            statusLow_r <= regWdata[2:0];
         end
         // timeout and powerdown are read-only to firmware
         if (powerRst) begin
            timeout_r   <= 1'b1;                            // [RULE7]
            powerdown_r <= 1'b1;
            statusLow_r <= STATUS_LOW_RST;
         end else if (borEvent) begin
            timeout_r   <= 1'b1;                            // [RULE9]
            powerdown_r <= 1'b1;
         end else if (pinRst & (state_r == ST_SLEEP)) begin
            timeout_r   <= 1'b1;                            // [RULE11]
            powerdown_r <= 1'b0;
         end else if (wdtRst) begin
            timeout_r <= 1'b0;                              // [RULE10]
         end else if (wdtWake) begin
            timeout_r   <= 1'b0;                            // [RULE10]
            powerdown_r <= 1'b0;
         end else if (intWake) begin
            timeout_r   <= 1'b1;                            // [RULE15]
            powerdown_r <= 1'b0;
         end else if (sleepEnter & (state_r == ST_RUN)) begin
            timeout_r   <= 1'b1;
            powerdown_r <= 1'b0;
         end
      end
   end

   // =====================================================
   // brown-out control
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         softBorEnable <= BOCTL_RST[1];
         borFastStart  <= BOCTL_RST[0];
      end else if (powerRst | borEvent) begin
         softBorEnable <= BOCTL_RST[1];
         borFastStart  <= BOCTL_RST[0];
      end else if (borCtlWr) begin
         softBorEnable <= regWdata[BIT_SOFT_BO];
         borFastStart  <= regWdata[BIT_FAST_BO];
      end
   end

   // =====================================================
   // read port, data one cycle after the strobe
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         regRdata <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            ADDR_PWRCTL: regRdata <= pwrCtl_r & PWRCTL_IMPL_MASK; // [RULE17]
            ADDR_BORCTL: regRdata <= {softBorEnable, borFastStart, 5'h00, borReady};
            ADDR_STATUS: regRdata <= {3'h0, timeout_r, powerdown_r, statusLow_r};
            default:     regRdata <= 8'h00;
         endcase
      end else begin
         regRdata <= 8'h00;
      end
   end

endmodule

// >>> rcs_reset_seq_chk.sv
// assertion checker for the reset-cause and start-up sequencer
`timescale 1ns/100ps
// =====================================================
// checker
module rcs_reset_seq_chk
   import rcs_pkg::*;
#(
   parameter int PWRT_CYCLES = PWRT_DEFAULT
) (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        porEvent,
   input wire logic        borEvent,
   input wire logic        progExit,
   input wire logic        powerupTimerEnableN,
   input wire logic        masterClearEnable,
   input wire logic        lowVoltProgEnable,
   input wire logic        masterClearPinN,
   input wire logic        wdtTimeout,
   input wire logic        resetOpcode,
   input wire logic        irqWake,
   input wire logic        borReady,
   input wire logic [10:0] curPc,
   input wire logic [1:0]  regAddr,
   input wire logic        regRd,
   input wire logic [7:0]  regRdata,
   input wire logic        cpuRun,
   input wire logic        pcLoad,
   input wire logic [10:0] pcValue,
   input wire logic        irqPush,
   input wire logic        sleeping
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [7:0]  pinHigh_r;
   logic [23:0] sincePwr_r;
   // both counters saturate so a long run cannot wrap them
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) pinHigh_r <= 8'h00;
      else if (!masterClearPinN) pinHigh_r <= 8'h00;
      else if (pinHigh_r != 8'hFF) pinHigh_r <= pinHigh_r + 8'h01;
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) sincePwr_r <= 24'h000000;
      else if (porEvent || borEvent || progExit) sincePwr_r <= 24'h000000;
      else if (sincePwr_r != 24'hFFFFFF) sincePwr_r <= sincePwr_r + 24'h000001;
   end
   a_hold_power: assert property ((porEvent || borEvent || progExit) |=> !cpuRun)
      else $error("core runs while a power reset is held");
   a_timer_first: assert property ($rose(cpuRun) && !powerupTimerEnableN |->
      sincePwr_r >= PWRT_CYCLES) else $error("run began before the power-up timer");
   a_pin_delay: assert property ($rose(cpuRun) && (masterClearEnable || lowVoltProgEnable)
      |-> pinHigh_r >= 8'h0A) else $error("run began too soon after pin release");
   a_reset_zero: assert property ((wdtTimeout || resetOpcode) && cpuRun && !sleeping
      |-> ##[1:2] (pcLoad && pcValue == RESET_VECTOR)) else $error("reset did not load zero");
   a_wake_next: assert property (irqWake && sleeping |-> ##[1:2]
      (pcLoad && pcValue == curPc + 11'h001)) else $error("wake did not load next address");
   a_vector_push: assert property (irqPush |-> pcLoad && pcValue == IRQ_VECTOR
      && $past(pcLoad)) else $error("vector load not after wake load");
   a_unused_zero: assert property (regRd && regAddr == ADDR_PWRCTL |=>
      !regRdata[BIT_UNUSED]) else $error("unused power-control bit reads one");
   a_ready_echo: assert property (regRd && regAddr == ADDR_BORCTL |=>
      regRdata[5:0] == {5'h00, $past(borReady)}) else $error("ready bit read wrong");
   c_push: cover property (irqPush);
   c_run: cover property ($rose(cpuRun));
   c_wdt_wake: cover property (wdtTimeout && sleeping);
endmodule

bind rcs_reset_seq rcs_reset_seq_chk #(.PWRT_CYCLES(PWRT_CYCLES)) rcs_reset_seq_chk_inst (
   .clk, .sys_rst, .porEvent, .borEvent, .progExit, .powerupTimerEnableN,
   .masterClearEnable, .lowVoltProgEnable, .masterClearPinN, .wdtTimeout, .resetOpcode,
   .irqWake, .borReady, .curPc, .regAddr, .regRd, .regRdata, .cpuRun, .pcLoad, .pcValue,
   .irqPush, .sleeping);

// >>> rcs_master_clear_pin_src.sv
// model of the external master-clear source with its weak pull-up
`timescale 1ns/100ps
// =====================================================
// pin driver
module rcs_master_clear_pin_src (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       pullLow,
   input  wire logic [7:0] holdCycles,
   output logic            masterClearPinN
);
   logic [7:0] left_r;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) left_r <= 8'h00;
      else if (pullLow) left_r <= holdCycles;
      else if (left_r != 8'h00) left_r <= left_r - 8'h01;
   end
   // once let go the pull-up returns the pin high, never a stale low
   assign masterClearPinN = (left_r == 8'h00);
endmodule

// >>> reset_cause_startup_seq_test.sv
// self-checking bench for the reset-cause and start-up sequencer
`timescale 1ns/100ps
module reset_cause_startup_seq_test
   import rcs_pkg::*;
;
   localparam int PWRT = 20;
   // event code, expected power-control value, expected status value
   localparam logic [19:0] ROWS [11] = '{20'h00F08, 20'h11B08, 20'h29F08, 20'h35F08,
      20'h41708, 20'h51E18, 20'h61D18, 20'h71F00, 20'h81F10, 20'h91710, 20'hA1D18};
   logic        clk, sys_rst, porEvent, borEvent, progExit, powerupTimerEnableN;
   logic        masterClearEnable, lowVoltProgEnable, stackResetEnable, masterClearPinN;
   logic        wdtTimeout, resetOpcode, stackOverflow, stackUnderflow, sleepEnter, irqWake;
   logic        globalIrqEnable, borReady, regWr, regRd, cpuRun, coreReset, pcLoad, irqPush;
   logic        sleeping, softBorEnable, borFastStart, pullLow;
   logic [10:0] curPc, pcValue;
   logic [1:0]  regAddr;
   logic [7:0]  regWdata, regRdata, holdCycles;
   int          errors = 0, n_checks = 0, cycles = 0, k;

   rcs_reset_seq #(.PWRT_CYCLES(PWRT)) rcs_reset_seq_inst (.clk, .sys_rst, .porEvent,
      .borEvent, .progExit, .powerupTimerEnableN, .masterClearEnable, .lowVoltProgEnable,
      .stackResetEnable, .masterClearPinN, .wdtTimeout, .resetOpcode, .stackOverflow,
      .stackUnderflow, .sleepEnter, .irqWake, .globalIrqEnable, .borReady, .curPc, .regAddr,
      .regWdata, .regWr, .regRd, .regRdata, .cpuRun, .coreReset, .pcLoad, .pcValue,
      .irqPush, .sleeping, .softBorEnable, .borFastStart);
   rcs_master_clear_pin_src rcs_master_clear_pin_src_inst (.clk, .sys_rst, .pullLow, .holdCycles, .masterClearPinN);

   initial clk = 1'b0;
   always #25 clk = ~clk;
   // =====================================================
   // tasks
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      chk(regRdata, exp);
      @(posedge clk);
   endtask
   task automatic fire(input int ev);
      if (ev >= 7 && ev <= 9) begin
         sleepEnter <= 1'b1;
         @(posedge clk);
         sleepEnter <= 1'b0;
         repeat (3) @(posedge clk);
      end
      case (ev)
         0, 7: wdtTimeout <= 1'b1;
         1: resetOpcode <= 1'b1;
         2: stackOverflow <= 1'b1;
         3: stackUnderflow <= 1'b1;
         4, 9: pullLow <= 1'b1;
         5: borEvent <= 1'b1;
         6: progExit <= 1'b1;
         8: irqWake <= 1'b1;
         default: porEvent <= 1'b1;
      endcase
      @(posedge clk);
      {wdtTimeout, resetOpcode, stackOverflow, stackUnderflow, pullLow, irqWake} <= 6'h00;
      repeat (3) @(posedge clk);
      {porEvent, borEvent, progExit} <= 3'h0;
   endtask
   // bounded wait until the core executes again
   task automatic wait_run(output int n);
      n = 0;
      while (!(cpuRun === 1'b1 && sleeping === 1'b0) && n < 300) begin
         @(posedge clk);
         n++;
      end
   endtask
   // =====================================================
   // main sequence
   initial begin
      {porEvent, borEvent, progExit, wdtTimeout, resetOpcode, stackOverflow} = 6'h00;
      {stackUnderflow, sleepEnter, irqWake, regWr, regRd, pullLow, borReady} = 7'h00;
      {powerupTimerEnableN, lowVoltProgEnable} = 2'h0;
      {masterClearEnable, stackResetEnable, globalIrqEnable, sys_rst} = 4'hF;
      curPc = 11'h123;
      regAddr = 2'h0;
      regWdata = 8'h00;
      holdCycles = 8'h28;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      wait_run(k);
      chk({7'h00, coreReset}, 8'h00);
      for (int i = 0; i < 11; i++) begin
         wr(ADDR_PWRCTL, 8'h1F);
         fire(int'(ROWS[i][19:16]));
         wait_run(k);
         rdc(ADDR_PWRCTL, ROWS[i][15:8]);
         rdc(ADDR_STATUS, ROWS[i][7:0]);
      end
      // second power-on in mid-run, pin held low well past the timer
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      pullLow <= 1'b1;
      @(posedge clk);
      pullLow <= 1'b0;
      rdc(ADDR_PWRCTL, 8'h1C);
      rdc(ADDR_STATUS, 8'h18);
      rdc(ADDR_BORCTL, 8'h80);
      chk({7'h00, coreReset}, 8'h01);
      while (masterClearPinN !== 1'b1) @(posedge clk);
      wait_run(k);
      chk({7'h00, k >= 9 && k <= 13}, 8'h01);
      wr(ADDR_PWRCTL, 8'hFF);
      rdc(ADDR_PWRCTL, 8'hDF);
      borReady <= 1'b1;
      wr(ADDR_BORCTL, 8'h40);
      rdc(ADDR_BORCTL, 8'h41);
      chk({6'h00, softBorEnable, borFastStart}, 8'h01);
      wr(2'h3, 8'hFF);
      rdc(2'h3, 8'h00);
      // stack reset off: no flag; pin off unless low-voltage enable is set
      stackResetEnable <= 1'b0;
      masterClearEnable <= 1'b0;
      holdCycles <= 8'h03;
      wr(ADDR_PWRCTL, 8'h1F);
      fire(2);
      fire(4);
      wait_run(k);
      rdc(ADDR_PWRCTL, 8'h1F);
      lowVoltProgEnable <= 1'b1;
      fire(4);
      wait_run(k);
      rdc(ADDR_PWRCTL, 8'h17);
      powerupTimerEnableN <= 1'b1;
      fire(6);
      wait_run(k);
      chk({7'h00, k < PWRT}, 8'h01);
      tally_and_finish();
   end
endmodule
